// ---- include/tcp_pkg.sv ----
package tcp_pkg;

    localparam int unsigned COUNT_WIDTH     = 8;
    localparam int unsigned CONTROL_WIDTH   = 8;
    localparam int unsigned PRESCALE_WIDTH  = 8;
    localparam int unsigned RATIO_WIDTH     = 3;

    // timer control register field positions
    localparam int unsigned CTRL_CLOCK_SOURCE_BIT = 5;
    localparam int unsigned CTRL_EDGE_SELECT_BIT  = 4;
    localparam int unsigned CTRL_PRESCALER_BIT    = 3;
    localparam int unsigned CTRL_RATIO_LSB        = 0;

    // clock source encoding
    localparam logic SOURCE_INSTRUCTION = 1'b0;
    localparam logic SOURCE_PIN         = 1'b1;
    // edge select encoding
    localparam logic EDGE_RISING        = 1'b0;
    localparam logic EDGE_FALLING       = 1'b1;
    // prescaler assignment: zero routes it to the counter
    localparam logic PRESCALER_TO_TIMER = 1'b0;

    localparam logic [COUNT_WIDTH-1:0]    COUNT_RESET    = 8'h00;
    localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 8'h00;
    localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_ONE   = 8'h01;
    localparam logic [COUNT_WIDTH-1:0]    COUNT_ONE      = 8'h01;
    localparam logic [COUNT_WIDTH-1:0]    COUNT_MAX      = 8'hFF;

    typedef struct packed {
        logic                   writeEnable;
        logic [COUNT_WIDTH-1:0] writeData;
    } tcp_write_type;

    typedef struct packed {
        logic                   clockSource;
        logic                   edgeSelect;
        logic                   prescalerAssign;
        logic [RATIO_WIDTH-1:0] ratio;
    } tcp_ctrl_type;

endpackage : tcp_pkg

// ---- logic/tcp_timer_counter.sv ----
// Behaviour
// [R1] pin source counts the pin edge chosen by control bit 4.
// [R2] instruction source counts every instruction cycle clock.
// [R3] core reads the count and overwrites it like any data register.
// [R4] prescaler sits in front of the counter while control bit 3 is zero.
// [R5] only a write to the count register clears the prescaler.
// [R6] control bit 5 picks pin edges or instruction clock as source.
`timescale 1ns/1ps
module tcp_timer_counter #(
    parameter int unsigned COUNT_WIDTH    = tcp_pkg::COUNT_WIDTH,
    parameter int unsigned PRESCALE_WIDTH = tcp_pkg::PRESCALE_WIDTH
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rstn,
    // external count pin
    input  wire logic                              externalCountPin,
    // timer control register contents
    input  wire logic [tcp_pkg::CONTROL_WIDTH-1:0] timerControlRegister,
    // core access to the count register
    input  wire tcp_pkg::tcp_write_type            countWrite,
    output logic      [COUNT_WIDTH-1:0]            countRegister,
    output logic                                   countOverflow
);

    ////////////////////////////////////////////////////////////////////////
    tcp_pkg::tcp_ctrl_type ctrl;

    always_comb begin
        ctrl.clockSource     = timerControlRegister[tcp_pkg::CTRL_CLOCK_SOURCE_BIT];
        ctrl.edgeSelect      = timerControlRegister[tcp_pkg::CTRL_EDGE_SELECT_BIT];
        ctrl.prescalerAssign = timerControlRegister[tcp_pkg::CTRL_PRESCALER_BIT];
        ctrl.ratio           = timerControlRegister[tcp_pkg::CTRL_RATIO_LSB +:
                                                    tcp_pkg::RATIO_WIDTH];
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    logic pinSync1;
    logic pinSync2;
    logic pinSync3;
    logic next_pinSync1;
    logic next_pinSync2;
    logic next_pinSync3;

    always_comb begin
        next_pinSync1 = externalCountPin;
        next_pinSync2 = pinSync1;
        next_pinSync3 = pinSync2;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinSync1 <= 1'b0;
            pinSync2 <= 1'b0;
            pinSync3 <= 1'b0;
        end else begin
            pinSync1 <= next_pinSync1;
            pinSync2 <= next_pinSync2;
            pinSync3 <= next_pinSync3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // filtered pin level and its edges
    logic pinAgree;
    logic pinLevel;
    logic next_pinLevel;
    logic pinRise;
    logic pinFall;

    always_comb begin
        // a level counts only once the last two stages agree
        pinAgree      = (pinSync2 == pinSync3);
        next_pinLevel = pinLevel;
        if (pinAgree) begin
            next_pinLevel = pinSync3;
        end
        pinRise = next_pinLevel & ~pinLevel;
        pinFall = ~next_pinLevel & pinLevel;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinLevel <= 1'b0;
        end else begin
            pinLevel <= next_pinLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // increment source
    logic pinEvent;
    logic sourceEvent;

    always_comb begin
        case (ctrl.edgeSelect)
            tcp_pkg::EDGE_RISING: begin
                pinEvent = pinRise; // [R1]
            end
            tcp_pkg::EDGE_FALLING: begin
                pinEvent = pinFall; // [R1]
            end
            default: begin
                pinEvent = 1'b0;
            end
        endcase
        case (ctrl.clockSource)
            tcp_pkg::SOURCE_PIN: begin // [R6]
                sourceEvent = pinEvent; // [R1]
            end
            tcp_pkg::SOURCE_INSTRUCTION: begin // [R6]
                sourceEvent = 1'b1; // [R2]
            end
            default: begin
                sourceEvent = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // divide ratio: two to the power of ratio plus one
    logic [tcp_pkg::RATIO_WIDTH:0] prescaleShift;
    logic [PRESCALE_WIDTH-1:0]     prescaleLast;
    logic                          prescaleOn;

    always_comb begin
        // one bit wider than the ratio, so the top ratio does not wrap to zero
        prescaleShift = {1'b0, ctrl.ratio} + 1'b1;
        prescaleLast  = PRESCALE_WIDTH'((tcp_pkg::PRESCALE_ONE << prescaleShift)
                                        - tcp_pkg::PRESCALE_ONE);
        prescaleOn    = (ctrl.prescalerAssign == tcp_pkg::PRESCALER_TO_TIMER); // [R4]
    end

    ////////////////////////////////////////////////////////////////////////
    // core write strobe
    logic                   writeStrobe;
    logic [COUNT_WIDTH-1:0] writeValue;

    always_comb begin
        writeStrobe = countWrite.writeEnable;
        writeValue  = COUNT_WIDTH'(countWrite.writeData);
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler
    logic [PRESCALE_WIDTH-1:0] prescaler;
    logic [PRESCALE_WIDTH-1:0] next_prescaler;
    logic                      countTick;

    always_comb begin
        next_prescaler = prescaler;
        countTick      = 1'b0;
        if (prescaleOn) begin // [R4]
            if (sourceEvent) begin
                // a lowered ratio lets a count above the new top tick at once
                if (prescaler >= prescaleLast) begin
                    next_prescaler = tcp_pkg::PRESCALE_RESET;
                    countTick      = 1'b1;
                end else begin
                    next_prescaler = PRESCALE_WIDTH'(prescaler + tcp_pkg::PRESCALE_ONE);
                end
            end
        end else begin
            countTick = sourceEvent;
        end
        // only a count write restarts the division
        if (writeStrobe) begin
            next_prescaler = tcp_pkg::PRESCALE_RESET; // [R5]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescaler <= tcp_pkg::PRESCALE_RESET;
        end else begin
            prescaler <= next_prescaler;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count register
    logic [COUNT_WIDTH-1:0] next_countRegister;

    always_comb begin
        next_countRegister = countRegister;
        // a write wins over an increment in the same cycle
        if (writeStrobe) begin
            next_countRegister = writeValue; // [R3]
        end else if (countTick) begin
            next_countRegister = COUNT_WIDTH'(countRegister + tcp_pkg::COUNT_ONE);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            countRegister <= tcp_pkg::COUNT_RESET;
        end else begin
            countRegister <= next_countRegister;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wrap flag, one cycle, raised only by an increment
    logic next_countOverflow;

    always_comb begin
        next_countOverflow = 1'b0;
        if (!writeStrobe && countTick) begin
            next_countOverflow = (countRegister == tcp_pkg::COUNT_MAX);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            countOverflow <= 1'b0;
        end else begin
            countOverflow <= next_countOverflow;
        end
    end

endmodule : tcp_timer_counter

// ---- tb/tcp_timer_counter_chk.sv ----
`timescale 1ns/1ps
module tcp_timer_counter_chk (
    // watched ports
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire logic                   externalCountPin,
    input wire logic [7:0]             timerControlRegister,
    input wire tcp_pkg::tcp_write_type countWrite,
    input wire logic [7:0]             countRegister,
    input wire logic                   countOverflow
);
    wire       we  = countWrite.writeEnable;
    wire [7:0] ctl = timerControlRegister;
    wire [7:0] cnt = countRegister;
    wire       pin = externalCountPin;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_wr; we |=> cnt == $past(countWrite.writeData) && !countOverflow; endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_inc; !we && !ctl[5] && ctl[3] |=> cnt == $past(cnt) + 8'h01
        && countOverflow == ($past(cnt) == 8'hFF); endproperty
    a_inc: assert property (p_inc) else $error("no step");
    property p_pre; !we && !ctl[5] && !ctl[3] && $stable(ctl) && $changed(cnt)
        |=> $stable(cnt); endproperty
    a_pre: assert property (p_pre) else $error("no divide");
    property p_clr; we ##1 !we && !ctl[5] && !ctl[3] && $stable(ctl) |=> $stable(cnt);
    endproperty
    a_clr: assert property (p_clr) else $error("divider kept");
    property p_pin; ctl[5] && !we && $stable(ctl) && $past(rstn, 5) && pin == $past(pin)
        && pin == $past(pin, 2) && pin == $past(pin, 3) && pin == $past(pin, 4)
        && pin == $past(pin, 5) |=> $stable(cnt); endproperty
    a_pin: assert property (p_pin) else $error("idle pin counted");
    property p_ovf; countOverflow |-> cnt == 8'h00 && $past(cnt) == 8'hFF; endproperty
    a_ovf: assert property (p_ovf) else $error("bad wrap");
    c_wr: cover property (we);
    c_ovf: cover property (countOverflow);
    c_pin: cover property (ctl[5] && $changed(cnt));
endmodule : tcp_timer_counter_chk
bind tcp_timer_counter tcp_timer_counter_chk i_chk (.clk(clk), .rstn(rstn),
    .externalCountPin(externalCountPin), .timerControlRegister(timerControlRegister),
    .countWrite(countWrite), .countRegister(countRegister), .countOverflow(countOverflow));

// ---- tb/tcp_pin_source.sv ----
`timescale 1ns/1ps
module tcp_pin_source (
    // clock and pin
    input wire logic clk,
    output logic     pin
);
    initial pin = 1'b0;
    // n rising and n-1 falling edges, w cycles apart, ends high
    task automatic burst(input int n, input int w);
        repeat (2 * n - 1) begin
            pin = ~pin;
            repeat (w) @(negedge clk);
        end
    endtask : burst
    task automatic idle();
        pin = 1'b0;
        repeat (6) @(negedge clk);
    endtask : idle
endmodule : tcp_pin_source

// ---- tb/tcp_timer_counter_bench.sv ----
`timescale 1ns/1ps
module tcp_timer_counter_bench;
    logic clk;
    logic rstn;
    logic pin;
    logic [7:0] ctl;
    logic [7:0] cnt;
    logic [7:0] expQ[$];
    tcp_pkg::tcp_write_type wr;
    int seed = 56;
    int badCount = 0;
    int compares = 0;
    event look;
    tcp_timer_counter i_dut (.clk(clk), .rstn(rstn), .externalCountPin(pin),
        .timerControlRegister(ctl), .countWrite(wr), .countRegister(cnt), .countOverflow());
    tcp_pin_source i_src (.clk(clk), .pin(pin));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask : check
    task automatic finalReport();
        $display("compares %0d bad %0d", compares, badCount);
        if (badCount == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finalReport
    task automatic note(input logic [7:0] v);
        expQ.push_back(v);
        -> look;
    endtask : note
    task automatic write(input logic [7:0] v);
        wr = '{1'b1, v};
        @(negedge clk);
        wr.writeEnable = 1'b0;
    endtask : write
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial forever begin
        @(look);
        #1 check(cnt, expQ.pop_front());
    end
    initial begin
        #50000 badCount++;
        finalReport();
    end
    initial begin
        rstn = 1'b0;
        ctl = 8'h28;
        wr = '0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        note(8'h00);
        ctl = 8'h08;
        write(8'hF0 | 8'($random(seed)));
        repeat (20) @(negedge clk);
        note(wr.writeData + 8'h14);
        $display("instruction source done");
        for (int r = 0; r < 8; r++) begin
            ctl = 8'(r);
            write(8'h00);
            repeat ((3 << (r + 1)) - 1) @(negedge clk);
            note(8'h02);
            @(negedge clk);
            note(8'h03);
            @(negedge clk);
        end
        $display("prescaler done");
        for (int e = 0; e < 2; e++) begin
            i_src.idle();
            ctl = 8'h28 | 8'(e << 4);
            write(8'h00);
            i_src.burst(4, 2 + ($random(seed) & 3));
            repeat (6) @(negedge clk);
            note(8'(4 - e));
        end
        $display("pin source done");
        @(negedge clk);
        finalReport();
    end
endmodule : tcp_timer_counter_bench
